// ---- bench/aars_host.sv ----
/*
  Host model: after each ready strobe reads the six results and one unmapped place.
  Assumes read data answers one cycle after the address.
*/
`timescale 1ns/1ps
module aars_host (
  input wire logic ref_clk,
  input wire logic result_ready,
  output logic [7:0] rd_addr = 8'h30,
  input wire logic [21:0] rd_data,
  output logic got_valid = 1'b0,
  output logic [21:0] got_data = '0
);
  // Seven reads take 21 cycles, well inside the gap before the next write
  always @(posedge ref_clk) begin
    if (result_ready === 1'b1) begin
      for (int i = 0; i < 7; i++) begin
        rd_addr <= 8'h2a + 8'(i);
        repeat (2) @(posedge ref_clk);
        got_data <= rd_data;
        got_valid <= 1'b1;
        @(posedge ref_clk);
        got_valid <= 1'b0;
      end
    end
  end
endmodule

// ---- bench/aars_sequencer_props.sv ----
/*
  Port checker for aars_sequencer.
  Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
module aars_sequencer_props #(
  parameter int NUM_AVG = 3,
  parameter int CONV_CYCLES = 500
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic conv_reset,
  input wire logic [7:0] rd_addr,
  input wire logic [21:0] rd_data,
  input wire logic conv_start,
  input wire logic result_ready
);
  // ---
  // Helpers
  // ---
  logic pr_q;
  logic [1:0] rc_q;
  int gap_q;
  int ns_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Gap and start counts restart on every pulse, since a pulse aborts the phase; the rise count does not
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pr_q <= 1'b0;
      rc_q <= 2'h0;
      gap_q <= 0;
      ns_q <= 0;
    end else begin
      pr_q <= conv_reset;
      rc_q <= rc_q + 2'(conv_reset & ~pr_q);
      gap_q <= conv_reset ? 0 : conv_start ? 1 : gap_q + int'(gap_q != 0);
      ns_q <= conv_reset ? 0 : ns_q + int'(conv_start);
    end
  end
  a_ready_after_rise: assert property (result_ready |-> $past(conv_reset) && !$past(conv_reset, 2))
    else $error("ready without rise");
  a_ready_one_cycle: assert property (result_ready |=> !result_ready)
    else $error("ready too long");
  // First rise after reset is the 0% pulse, so ready follows rises 5, 9 and on
  a_ready_fourth_rise: assert property (result_ready |-> rc_q == 2'h1)
    else $error("ready off the fourth rise");
  a_start_after_fall: assert property ($fell(conv_reset) |-> ##[1:2] conv_start)
    else $error("no conversion after fall");
  a_pulse_blocks_start: assert property (conv_reset |=> !conv_start)
    else $error("early conversion");
  a_conv_spacing: assert property (conv_start && gap_q != 0 |-> gap_q == CONV_CYCLES)
    else $error("bad conversion spacing");
  a_conv_count: assert property (conv_start |-> ns_q < NUM_AVG)
    else $error("too many conversions");
  a_read_stable: assert property ($stable(rd_addr) && !conv_reset && !pr_q |=>
    $stable(rd_data)) else $error("result moved");
  c_ready: cover property (result_ready);
  c_last_conv: cover property (conv_start && ns_q == NUM_AVG - 1);
  c_fall: cover property ($fell(conv_reset));
endmodule
bind aars_sequencer aars_sequencer_props #(.NUM_AVG(NUM_AVG), .CONV_CYCLES(CONV_CYCLES))
  i_props (.ref_clk, .resetn, .conv_reset, .rd_addr, .rd_data, .conv_start, .result_ready);

// ---- bench/aars_sequencer_tb.sv ----
/*
  Testbench: two full periods of four phases, results read by the host model.
  Assumes design, package, checker and host model are compiled first.
*/
`timescale 1ns/1ps
module aars_sequencer_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_reset = 1'b0;
  logic sample_valid = 1'b0;
  logic [21:0] sample_data = '0;
  logic [7:0] rd_addr;
  logic [21:0] rd_data, got_data, prev = '0;
  logic conv_start, result_ready, got_valid;
  logic [21:0] exp_q[$];
  logic [21:0] res[4];
  logic [31:0] seed = 32'h0001561d;
  logic [23:0] sum;
  logic [22:0] t;
  logic [31:0] n_starts = '0;
  logic [31:0] n_ready = '0;
  int slot = 3;
  int n_rise = 0;
  int failures = 0;
  int n_tests = 0;
  always #50 ref_clk = ~ref_clk;
  aars_sequencer #(.NUM_AVG(3), .CONV_CYCLES(5)) i_aars_sequencer (.ref_clk, .resetn,
    .conv_reset, .sample_valid, .sample_data, .rd_addr, .rd_data, .conv_start, .result_ready);
  aars_host i_aars_host (.ref_clk, .result_ready, .rd_addr, .rd_data, .got_valid, .got_data);
  task automatic cmp(input logic [21:0] e, input logic [21:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_count(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Counts see each output before the edge's own updates land
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) n_starts <= n_starts + 32'h1;
    if (result_ready === 1'b1) n_ready <= n_ready + 32'h1;
  end
  // ---
  // One phase: pulse, then six samples; the last three land after the third
  // conversion so they must not count
  // ---
  task automatic phase();
    logic [31:0] starts0;
    conv_reset <= 1'b1;
    res[slot] = prev;
    n_rise++;
    // First pulse after reset is the 0% one; ready needs a full period behind it
    if (slot == 3 && n_rise > 1) begin
      for (int i = 0; i < 4; i++) exp_q.push_back(res[i]);
      t = {1'b0, res[0]} + {1'b0, res[1]};
      exp_q.push_back(t[22:1]);
      t = {1'b0, res[2]} + {1'b0, res[3]};
      exp_q.push_back(t[22:1]);
      exp_q.push_back('0);
    end
    slot = (slot + 1) % 4;
    @(posedge ref_clk);
    conv_reset <= 1'b0;
    starts0 = n_starts;
    sum = '0;
    for (int i = 0; i < 30; i++) begin
      @(posedge ref_clk);
      seed = lfsr_next(seed);
      sample_valid <= (i % 5 == 2);
      sample_data <= seed[21:0];
      if (i % 5 == 2 && i < 15) sum += {2'h0, seed[21:0]};
    end
    cmp_count(32'h3, n_starts - starts0);
    prev = 22'(sum / 24'h3);
  endtask
  always @(posedge ref_clk) begin
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp('1, got_data);
      else cmp(exp_q.pop_front(), got_data);
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      repeat (4) phase();
      $display("period %0d done, comparisons %0d", p, n_tests);
    end
    // Closing 0% pulse completes the second period and its ready strobe
    phase();
    for (int w = 0; w < 100 && exp_q.size() != 0; w++) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      failures++;
      $display("timeout: %0d results never read", exp_q.size());
    end
    cmp_count(32'h2, n_ready);
    print_verdict();
  end
endmodule

// ---- hw/aars_defs.svh ----
/*
  Constants for the averaging result sequencer: register offsets, widths, counts.
  Assumes inclusion by its bare name from the package and the design module.
*/
`ifndef AARS_DEFS_SVH
`define AARS_DEFS_SVH
`define AARS_RES_W 22
`define AARS_SAMPLE_W 22
`define AARS_ACC_W 24
`define AARS_ADDR_W 8
`define AARS_OFF_SECOND_EMITTER 8'h2a
`define AARS_OFF_SECOND_AMBIENT 8'h2b
`define AARS_OFF_FIRST_EMITTER 8'h2c
`define AARS_OFF_FIRST_AMBIENT 8'h2d
`define AARS_OFF_SECOND_PAIR 8'h2e
`define AARS_OFF_FIRST_PAIR 8'h2f
`define AARS_RES_RESET 22'h000000
`define AARS_NUM_AVG 3
`define AARS_CLK_HZ 10000000
`define AARS_CONV_TIME_NS 50000
`define AARS_CONV_CYCLES ((`AARS_CONV_TIME_NS * (`AARS_CLK_HZ / 1000000)) / 1000)
`endif

// ---- hw/aars_pkg.sv ----
/*
  Types for the averaging result sequencer.
  Assumes aars_defs.svh is on the include path.
*/
`include "aars_defs.svh"
package aars_pkg;
  typedef logic [`AARS_RES_W-1:0] aars_res_t;
  typedef enum logic [3:0] {
    AARS_IDLE = 4'b0001,
    AARS_CONV = 4'b0010,
    AARS_DONE = 4'b0100,
    AARS_HOLD = 4'b1000
  } aars_state_t;
endpackage

// ---- hw/aars_sequencer.sv ----
/*
  Averaging result sequencer: times conversions after each converter reset pulse,
  averages the samples of each phase, stores four averages and two pair results,
  and raises a ready strobe once per period.
  Assumes conv_reset comes from the timing engine on ref_clk, sample_data is valid
  when sample_valid pulses, and the host reads results through the read port.
*/
`timescale 1ns/1ps
`include "aars_defs.svh"
module aars_sequencer #(
  parameter int NUM_AVG = `AARS_NUM_AVG,
  parameter int CONV_CYCLES = `AARS_CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic conv_reset,
  input wire logic sample_valid,
  input wire logic [`AARS_SAMPLE_W-1:0] sample_data,
  input wire logic [`AARS_ADDR_W-1:0] rd_addr,
  output logic [`AARS_RES_W-1:0] rd_data,
  output logic conv_start,
  output logic result_ready
);

  // ----------------------------------------------------------------
  // Reset edge detection
  // ----------------------------------------------------------------
  // Timing engine shares ref_clk, so the pulse needs no synchroniser
  logic rst_seen_q;
  logic rst_rise;
  logic rst_fall;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= conv_reset;
    end
  end
  assign rst_rise = conv_reset & ~rst_seen_q;
  assign rst_fall = ~conv_reset & rst_seen_q;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  aars_pkg::aars_state_t state_q;
  logic [15:0] conv_cnt_q;
  logic [7:0] conv_num_q;
  logic conv_end;
  assign conv_end = (state_q == aars_pkg::AARS_CONV) &&
                    (conv_cnt_q == 16'(CONV_CYCLES - 1));

  // Phase ends early if the next reset arrives; partial averages still land
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= aars_pkg::AARS_IDLE;
      conv_cnt_q <= 16'h0000;
      conv_num_q <= 8'h00;
    end else begin
      case (state_q)
        aars_pkg::AARS_IDLE: begin
          if (rst_fall) begin
            state_q <= aars_pkg::AARS_CONV;
            conv_cnt_q <= 16'h0000;
            conv_num_q <= 8'h00;
          end
        end
        aars_pkg::AARS_CONV: begin
          if (rst_rise) begin
            state_q <= aars_pkg::AARS_IDLE;
          end else if (conv_end) begin
            conv_cnt_q <= 16'h0000;
            conv_num_q <= conv_num_q + 8'h01;
            if (conv_num_q == 8'(NUM_AVG - 1)) begin
              state_q <= aars_pkg::AARS_DONE;
            end
          end else begin
            conv_cnt_q <= conv_cnt_q + 16'h0001;
          end
        end
        aars_pkg::AARS_DONE: begin
          if (rst_rise) begin
            state_q <= aars_pkg::AARS_IDLE;
          end
        end
        default: begin
          state_q <= aars_pkg::AARS_IDLE;
        end
      endcase
    end
  end
  assign conv_start = (state_q == aars_pkg::AARS_CONV) && (conv_cnt_q == 16'h0000);

  // ----------------------------------------------------------------
  // Accumulation
  // ----------------------------------------------------------------
  logic [`AARS_ACC_W-1:0] acc_q;
  logic [7:0] acc_n_q;
  logic take;
  // Rise and fall both clear, so nothing from before the pulse carries over
  assign take = sample_valid && (state_q == aars_pkg::AARS_CONV) &&
                (acc_n_q < 8'(NUM_AVG));
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
      acc_n_q <= 8'h00;
    end else if (rst_rise || rst_fall) begin
      acc_q <= '0;
      acc_n_q <= 8'h00;
    end else if (take) begin
      acc_q <= acc_q + `AARS_ACC_W'(sample_data);
      acc_n_q <= acc_n_q + 8'h01;
    end
  end

  // Combinational divider; cheap at this clock, a timing cost at faster ones
  // Divide by samples actually taken; zero samples gives zero
  function automatic aars_pkg::aars_res_t avg_of(input logic [`AARS_ACC_W-1:0] a,
                                                 input logic [7:0] n);
    if (n == 8'h00) begin
      avg_of = '0;
    end else begin
      avg_of = `AARS_RES_W'(a / `AARS_ACC_W'(n));
    end
  endfunction

  // Pair combine is unspecified; the mean keeps it in 22 bits
  function automatic aars_pkg::aars_res_t pair_of(input aars_pkg::aars_res_t x,
                                                  input aars_pkg::aars_res_t y);
    logic [`AARS_RES_W:0] s;
    s = {1'b0, x} + {1'b0, y};
    pair_of = s[`AARS_RES_W:1];
  endfunction

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Slot tracks which quarter reset comes next; 0 means the 25% reset
  // Reset value 3: the first rise after reset is taken as the 0% pulse
  logic [1:0] slot_q;
  logic [3:0] valid_q;
  aars_pkg::aars_res_t sec_em_q, sec_amb_q, fir_em_q, fir_amb_q, sec_pair_q, fir_pair_q;
  aars_pkg::aars_res_t avg;
  assign avg = avg_of(acc_q, acc_n_q);

  // Sequencing counts reset rises only; placement at quarters is the timer's job
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 2'h3;
      valid_q <= 4'h0;
      sec_em_q <= `AARS_RES_RESET;
      sec_amb_q <= `AARS_RES_RESET;
      fir_em_q <= `AARS_RES_RESET;
      fir_amb_q <= `AARS_RES_RESET;
      sec_pair_q <= `AARS_RES_RESET;
      fir_pair_q <= `AARS_RES_RESET;
    end else if (rst_rise) begin
      slot_q <= slot_q + 2'h1;
      case (slot_q)
        2'h0: begin
          sec_em_q <= avg;
          valid_q <= 4'h1;
        end
        2'h1: begin
          sec_amb_q <= avg;
          valid_q[1] <= valid_q[0];
        end
        2'h2: begin
          fir_em_q <= avg;
          valid_q[2] <= valid_q[1];
        end
        default: begin
          fir_amb_q <= avg;
          sec_pair_q <= pair_of(sec_em_q, sec_amb_q);
          fir_pair_q <= pair_of(fir_em_q, avg);
          valid_q[3] <= valid_q[2];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ready strobe and read port
  // ----------------------------------------------------------------
  // One-cycle pulse registered on the same edge as the 0% updates, only for a full period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_ready <= 1'b0;
    end else begin
      result_ready <= rst_rise && (slot_q == 2'h3) && valid_q[2];
    end
  end

  // Read data lags the address by one clock; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      case (rd_addr)
        `AARS_OFF_SECOND_EMITTER: rd_data <= sec_em_q;
        `AARS_OFF_SECOND_AMBIENT: rd_data <= sec_amb_q;
        `AARS_OFF_FIRST_EMITTER: rd_data <= fir_em_q;
        `AARS_OFF_FIRST_AMBIENT: rd_data <= fir_amb_q;
        `AARS_OFF_SECOND_PAIR: rd_data <= sec_pair_q;
        `AARS_OFF_FIRST_PAIR: rd_data <= fir_pair_q;
        default: rd_data <= '0;
      endcase
    end
  end

endmodule
